// ==== core/pmsp_defs.svh ====
`ifndef PMSP_DEFS_SVH
`define PMSP_DEFS_SVH

// Address width and register byte offsets.
`define PMSP_AW          12
`define PMSP_OFF_MCMD    12'h090
`define PMSP_OFF_DATA    12'h094
`define PMSP_OFF_CTL     12'h098

// Reset values.
`define PMSP_MCMD_RST    32'h00400000
`define PMSP_DATA_RST    32'h00000000

// Field positions.
`define PMSP_MCMD_SPD    20
`define PMSP_MCMD_FDX    18
`define PMSP_CTL_REG_LSB 0
`define PMSP_CTL_PHY_LSB 8
`define PMSP_CTL_WR      16
`define PMSP_CTL_BUSY    17
`define PMSP_CTL_EN_ALT  18
`define PMSP_CTL_EN      19

// Divider setting width and serial frame counts.
`define PMSP_DIV_W       8
`define PMSP_FRAME_LEN   7'd64
`define PMSP_DRIVE_RD    7'd46
`define PMSP_SAMPLE_1ST  7'd49
`define PMSP_ST_IDX      7'd32
`define PMSP_OP_IDX      7'd34
`define PMSP_TA_IDX      7'd46

`endif

// ==== core/pmsp_pkg.sv ====
package pmsp_pkg;

  typedef enum logic [1:0] {
    PMSP_IDLE  = 2'b01,
    PMSP_SHIFT = 2'b10
  } pmsp_state_e;

  typedef struct packed {
    logic       clk_en;
    logic       busy;
    logic       wr;
    logic [4:0] phy;
    logic [4:0] regn;
  } pmsp_ctl_s;

  typedef logic [63:0] pmsp_frame_t;

endpackage : pmsp_pkg

// ==== core/pmsp_clk_div.sv ====
`timescale 1ns/1ps
`include "pmsp_defs.svh"

module pmsp_clk_div import pmsp_pkg::*; (
  input  wire logic                   clk_i,   // System clock.
  input  wire logic                   reset_i, // Async reset, high.
  input  wire logic                   en_i,    // Run the clock.
  input  wire logic [`PMSP_DIV_W-1:0] div_i,   // Divider setting.
  output logic                        mdc_o,   // Serial clock level.
  output logic                        rise_o,  // Clock rises next edge.
  output logic                        fall_o   // Clock falls next edge.
);

  logic [`PMSP_DIV_W-1:0] cnt;
  logic [`PMSP_DIV_W-1:0] top;
  logic [`PMSP_DIV_W-1:0] half;

  // A setting of zero would ask for a full-rate clock, which a
  // registered divider cannot make; the period is held at two.
  assign top  = (div_i == '0) ? `PMSP_DIV_W'(1) : div_i;
  assign half = `PMSP_DIV_W'((9'(top) + 9'd1) >> 1);
  assign rise_o = en_i && (cnt == top);
  assign fall_o = en_i && (cnt == half - `PMSP_DIV_W'(1));

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= '0;
    end else if (!en_i || cnt >= top) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + `PMSP_DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mdc_o <= 1'b0;
    end else if (rise_o) begin
      mdc_o <= 1'b1;
    end else if (fall_o || !en_i) begin
      mdc_o <= 1'b0;
    end
  end

endmodule : pmsp_clk_div

// ==== core/pmsp_sync.sv ====
`timescale 1ns/1ps

module pmsp_sync import pmsp_pkg::*; (
  input  wire logic clk_i,   // System clock.
  input  wire logic reset_i, // Async reset, high.
  input  wire logic d_i,     // Pin level.
  output logic      q_o      // Synchronised level.
);

  logic meta;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= 1'b1;
      q_o  <= 1'b1;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule : pmsp_sync

// ==== core/pmsp_top.sv ====
// Overview of operation
// - The serial clock runs at the system clock over divider plus one; a divider of zero gives two.
// - The serial clock stays still until the clock enable bit is set.
// - The serial clock only serves register access and may stop idle.
// - Writing busy and clock enable with write clear starts a read.
// - Busy reads one for the whole read and falls when it is done.
// - A finished read puts the returned value into the data register.
// - Write, busy and enable together send the data to the PHY.
// - Busy falls once the serial write has fully completed.
// - The speed and duplex bits are held and driven to the MAC.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "pmsp_defs.svh"

module pmsp_top import pmsp_pkg::*; (
  input  wire logic                   clk_i,       // 200 MHz clock.
  input  wire logic                   reset_i,     // Async reset, high.
  input  wire logic [`PMSP_AW-1:0]    addr_i,      // Byte address.
  input  wire logic [31:0]            wdata_i,     // Write data.
  input  wire logic                   wr_i,        // Write strobe.
  input  wire logic                   rd_i,        // Read strobe.
  output logic      [31:0]            rdata_o,     // Read data.
  input  wire logic [`PMSP_DIV_W-1:0] mgmt_clock_divider_i, // Divider.
  output logic                        mdc_o,       // Serial clock pin.
  input  wire logic                   mdio_i,      // Data pin in.
  output logic                        mdio_o,      // Data pin out.
  output logic                        mdio_oe_o,   // Data pin drive.
  output logic                        speed_select_o,       // 100M mode.
  output logic                        full_duplex_select_o  // Full duplex.
);

  pmsp_state_e state;
  pmsp_ctl_s   ctl;
  logic [31:0] mac_command;
  logic [31:0] phy_mgmt_data;
  pmsp_frame_t tx_shift;
  logic [15:0] rx_shift;
  logic [6:0]  bit_idx;
  logic        mdio_s;
  logic        tick_rise;
  logic        tick_fall;
  logic        wr_ctl;
  logic        wr_data;
  logic        wr_mcmd;
  logic        start;
  logic        done;
  logic        wdata_en;

  function automatic pmsp_frame_t build_frame(
    input logic        wr,
    input logic [4:0]  phy,
    input logic [4:0]  regn,
    input logic [15:0] data
  );
    build_frame = {32'hffffffff, 2'b01,
                   wr ? 2'b01 : 2'b10, phy, regn,
                   wr ? 2'b10 : 2'b11, data};
  endfunction : build_frame

  assign wr_ctl  = wr_i && (addr_i == `PMSP_OFF_CTL);
  assign wr_data = wr_i && (addr_i == `PMSP_OFF_DATA);
  assign wr_mcmd = wr_i && (addr_i == `PMSP_OFF_MCMD);
  // Either enable position turns the clock on, since both are in use.
  assign wdata_en = wdata_i[`PMSP_CTL_EN] || wdata_i[`PMSP_CTL_EN_ALT];
  // A busy request without the enable would wait for a clock that
  // never comes, so it is not started.
  assign start = wr_ctl && !ctl.busy && wdata_i[`PMSP_CTL_BUSY]
                 && wdata_en;
  assign done  = (state == PMSP_SHIFT) && tick_fall
                 && (bit_idx == `PMSP_FRAME_LEN);

  pmsp_clk_div u_div (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .en_i    (ctl.clk_en),
    .div_i   (mgmt_clock_divider_i),
    .mdc_o   (mdc_o),
    .rise_o  (tick_rise),
    .fall_o  (tick_fall)
  );

  pmsp_sync u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (mdio_i),
    .q_o     (mdio_s)
  );

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mac_command <= `PMSP_MCMD_RST;
    end else if (wr_mcmd) begin
      mac_command <= wdata_i;
    end
  end

  assign speed_select_o       = mac_command[`PMSP_MCMD_SPD];
  assign full_duplex_select_o = mac_command[`PMSP_MCMD_FDX];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl <= '0;
    end else if (wr_ctl && !ctl.busy) begin
      ctl.clk_en <= wdata_en;
      ctl.busy   <= start;
      ctl.wr     <= wdata_i[`PMSP_CTL_WR];
      ctl.phy    <= wdata_i[`PMSP_CTL_PHY_LSB +: 5];
      ctl.regn   <= wdata_i[`PMSP_CTL_REG_LSB +: 5];
    end else if (done) begin
      ctl.busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= PMSP_IDLE;
    end else begin
      unique case (state)
        PMSP_IDLE: begin
          if (start) begin
            state <= PMSP_SHIFT;
          end
        end
        PMSP_SHIFT: begin
          if (done) begin
            state <= PMSP_IDLE;
          end
        end
        default: begin
          state <= PMSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phy_mgmt_data <= `PMSP_DATA_RST;
    end else if (wr_data && !ctl.busy) begin
      phy_mgmt_data <= wdata_i;
    end else if (done && !ctl.wr) begin
      phy_mgmt_data <= {16'h0000, rx_shift};
    end
  end

  // Bits leave on the falling edge so the PHY sees them settled at
  // the rising edge; a full half period of setup is kept.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_shift  <= '0;
      bit_idx   <= '0;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (start) begin
      tx_shift <= build_frame(wdata_i[`PMSP_CTL_WR],
                              wdata_i[`PMSP_CTL_PHY_LSB +: 5],
                              wdata_i[`PMSP_CTL_REG_LSB +: 5],
                              phy_mgmt_data[15:0]);
      bit_idx  <= '0;
    end else if (done) begin
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (state == PMSP_SHIFT && tick_fall) begin
      mdio_o    <= tx_shift[63];
      mdio_oe_o <= ctl.wr || (bit_idx < `PMSP_DRIVE_RD);
      tx_shift  <= {tx_shift[62:0], 1'b0};
      bit_idx   <= bit_idx + 7'd1;
    end
  end

  // The sampled level lags the pin by the two synchroniser stages,
  // which bounds how fast the serial clock may be set.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_shift <= '0;
    end else if (state == PMSP_SHIFT && tick_rise && !ctl.wr
                 && bit_idx >= `PMSP_SAMPLE_1ST) begin
      rx_shift <= {rx_shift[14:0], mdio_s};
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        `PMSP_OFF_MCMD: rdata_o <= mac_command;
        `PMSP_OFF_DATA: rdata_o <= phy_mgmt_data;
        `PMSP_OFF_CTL: begin
          rdata_o <= '0;
          rdata_o[`PMSP_CTL_EN]   <= ctl.clk_en;
          rdata_o[`PMSP_CTL_BUSY] <= ctl.busy;
          rdata_o[`PMSP_CTL_WR]   <= ctl.wr;
          rdata_o[`PMSP_CTL_PHY_LSB +: 5] <= ctl.phy;
          rdata_o[`PMSP_CTL_REG_LSB +: 5] <= ctl.regn;
        end
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  AST_BUSY_MATCHES_FRAME: assert property (
    ctl.busy == (state == PMSP_SHIFT))
    else $error("busy does not track the frame");

  AST_MDC_STILL_WHEN_OFF: assert property (
    !ctl.clk_en && !$past(ctl.clk_en) |-> !mdc_o && !tick_fall)
    else $error("serial clock moves while disabled");

  AST_START_SETS_BUSY: assert property (
    start |=> ctl.busy && state == PMSP_SHIFT && bit_idx == 7'd0)
    else $error("start did not open a frame");

  AST_READ_RESULT: assert property (
    done && !ctl.wr |=> phy_mgmt_data == {16'h0000, $past(rx_shift)})
    else $error("read result not stored");

  AST_READ_RELEASE: assert property (
    state == PMSP_SHIFT && !ctl.wr && bit_idx > `PMSP_DRIVE_RD
    |-> !mdio_oe_o)
    else $error("data pin driven in read turnaround");

  AST_WRITE_DRIVES: assert property (
    state == PMSP_SHIFT && ctl.wr && bit_idx != 7'd0 |-> mdio_oe_o)
    else $error("write frame not driven");

  AST_START_BITS: assert property (
    state == PMSP_SHIFT && tick_fall && bit_idx == `PMSP_ST_IDX
    |=> !mdio_o ##0 mdio_oe_o)
    else $error("start pattern wrong");

  AST_DONE_CLEARS: assert property (
    done |=> !ctl.busy ##1 !ctl.busy || $past(start))
    else $error("busy not cleared at completion");

  AST_IGNORE_BUSY: assert property (
    wr_data && ctl.busy && !done |=> $stable(phy_mgmt_data))
    else $error("data register changed while busy");

  AST_MODE_BITS: assert property (
    wr_mcmd |=> speed_select_o == $past(wdata_i[`PMSP_MCMD_SPD])
    && full_duplex_select_o == $past(wdata_i[`PMSP_MCMD_FDX]))
    else $error("mode bits not taken");

  AST_RDATA_QUIET: assert property (
    !$past(rd_i) |-> rdata_o == 32'h00000000)
    else $error("read data shown without a read");

  AST_IDLE_RELEASED: assert property (
    state == PMSP_IDLE |-> !mdio_oe_o && !mdio_o)
    else $error("data pin driven outside a frame");

  AST_NO_EN_NO_START: assert property (
    wr_ctl && !ctl.busy && wdata_i[`PMSP_CTL_BUSY] && !wdata_en
    |=> !ctl.busy && state == PMSP_IDLE)
    else $error("busy started without the clock enable");

  AST_BIT_COUNT_RANGE: assert property (
    state == PMSP_SHIFT |-> bit_idx <= `PMSP_FRAME_LEN)
    else $error("frame ran past its last bit");

  AST_OPCODE_FIRST: assert property (
    state == PMSP_SHIFT && tick_fall && bit_idx == `PMSP_OP_IDX
    |=> mdio_o == !ctl.wr && mdio_oe_o)
    else $error("opcode first bit wrong");

  AST_WRITE_TURNAROUND: assert property (
    state == PMSP_SHIFT && ctl.wr && tick_fall
    && bit_idx == `PMSP_TA_IDX |=> mdio_o && mdio_oe_o)
    else $error("write turnaround not driven high");

  AST_CTL_HELD_BUSY: assert property (
    wr_ctl && ctl.busy |=> $stable(ctl.phy) && $stable(ctl.regn)
                           && $stable(ctl.wr) && ctl.clk_en)
    else $error("control register changed while busy");

  AST_MDC_RISE_TICK: assert property (
    tick_rise |=> mdc_o)
    else $error("serial clock missed its rising tick");

  AST_MDC_FALL_TICK: assert property (
    tick_fall |=> !mdc_o)
    else $error("serial clock missed its falling tick");

  AST_RX_HELD_WRITE: assert property (
    state == PMSP_SHIFT && ctl.wr |=> $stable(rx_shift))
    else $error("read shifter moved during a write frame");

  COV_READ_DONE: cover property (done && !ctl.wr);
  COV_WRITE_DONE: cover property (done && ctl.wr);
  COV_BUSY_WRITE: cover property (wr_ctl && ctl.busy);
  COV_MODE_SET: cover property (wr_mcmd && wdata_i[`PMSP_MCMD_SPD]);
  COV_ALT_ENABLE: cover property (start && !wdata_i[`PMSP_CTL_EN]);

endmodule : pmsp_top

// ==== dv/pmsp_phy_model.sv ====
`timescale 1ns/1ps

module pmsp_phy_model (
  input  wire logic        mdc_i,      // Serial clock.
  input  wire logic        mdio_o_i,   // Device data out.
  input  wire logic        mdio_oe_i,  // Device drive enable.
  output logic             mdio_pin_o, // Resolved wire level.
  output logic [63:0]      frame_o     // Last whole frame seen.
);
  logic [6:0]  cnt   = 7'h00;
  logic [63:0] sr    = 64'h0;
  logic [15:0] rval  = 16'h0;
  logic        rd    = 1'b0;
  logic        drv   = 1'b0;
  logic        bit_v = 1'b0;
  logic        last  = 1'b0;

  // Undriven wire shows the inverse of its last level, so a design that
  // samples a released line cannot pass by luck.
  assign mdio_pin_o = mdio_oe_i ? mdio_o_i : (drv ? bit_v : ~last);

  always @(posedge mdc_i) begin
    if (cnt != 7'h00 || mdio_oe_i) begin
      sr  <= {sr[62:0], mdio_pin_o};
      cnt <= (cnt == 7'd63) ? 7'h00 : cnt + 7'h01;
      if (cnt == 7'd63)
        frame_o <= {sr[62:0], mdio_pin_o};
      if (cnt == 7'd45) begin
        rval <= {3'h5, sr[8:4], 3'h3, sr[3:0], mdio_pin_o};
        rd   <= sr[10] & ~sr[9];
      end
    end
  end

  // The partner drives from the second turnaround bit on and changes on the fall.
  always @(negedge mdc_i) begin
    last  <= mdio_pin_o;
    drv   <= rd && cnt >= 7'd47;
    bit_v <= (cnt >= 7'd48) ? rval[4'(7'd63 - cnt)] : 1'b0;
  end
endmodule : pmsp_phy_model

// ==== dv/tb_phy_mgmt_serial_port.sv ====
`timescale 1ns/1ps
`include "pmsp_defs.svh"

module tb_phy_mgmt_serial_port;
  logic        clk_i   = 1'b0;
  logic        reset_i = 1'b1;
  logic [11:0] addr_i  = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [7:0]  div     = 8'h07;
  logic [31:0] rdata_o;
  logic        mdc_o;
  logic        mdio_i;
  logic        mdio_o;
  logic        mdio_oe_o;
  logic        spd;
  logic        fdx;
  logic [63:0] frame;
  int          mismatches      = 0;
  int          samples_checked = 0;
  int          rises           = 0;

  pmsp_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .mgmt_clock_divider_i(div), .mdc_o(mdc_o), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .speed_select_o(spd),
    .full_duplex_select_o(fdx));

  pmsp_phy_model i_phy (.mdc_i(mdc_o), .mdio_o_i(mdio_o),
    .mdio_oe_i(mdio_oe_o), .mdio_pin_o(mdio_i), .frame_o(frame));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge mdc_o) rises++;

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask : rd

  task automatic wait_idle();
    logic [31:0] v;
    int          k;
    k = 0;
    v = 32'h00020000;
    while (v[17] === 1'b1 && k < 400) begin
      rd(`PMSP_OFF_CTL, v);
      k++;
    end
    chk("busy_end", 64'h0, {63'h0, v[17]});
  endtask : wait_idle

  task automatic t_reset();
    logic [31:0] v;
    repeat (30) @(posedge clk_i);
    chk("idle_rises", 64'h0, rises);
    chk("reset_mode", 64'h0, {62'h0, spd, fdx});
    chk("reset_pin", 64'h0, {62'h0, mdio_oe_o, mdio_o});
    rd(`PMSP_OFF_MCMD, v);
    chk("mcmd_rst", `PMSP_MCMD_RST, v);
    rd(`PMSP_OFF_DATA, v);
    chk("data_rst", `PMSP_DATA_RST, v);
    rd(`PMSP_OFF_CTL, v);
    chk("ctl_rst", 64'h0, v);
    rd(12'h09c, v);
    chk("unmapped", 64'h0, v);
  endtask : t_reset

  task automatic t_period(input logic [7:0] n);
    longint t0;
    int     r;
    div <= n;
    wr(`PMSP_OFF_CTL, 32'h00080000);
    @(posedge mdc_o);
    t0 = $time;
    @(posedge mdc_o);
    chk("period", n + 1, ($time - t0) / 5);
    wr(`PMSP_OFF_CTL, 32'h0);
    r = rises;
    repeat (40) @(posedge clk_i);
    chk("stopped", r, rises);
  endtask : t_period

  task automatic t_noen();
    logic [31:0] v;
    wr(`PMSP_OFF_CTL, 32'h00020305);
    rd(`PMSP_OFF_CTL, v);
    chk("no_start", 64'h00000305, v);
  endtask : t_noen

  task automatic t_read(input logic [4:0] p, input logic [4:0] r,
                        output logic [15:0] got);
    logic [31:0] v;
    wr(`PMSP_OFF_CTL, {13'h0, 2'b11, 4'h0, p, 3'h0, r});
    rd(`PMSP_OFF_CTL, v);
    chk("rd_busy", {32'h0, 12'h00a, 3'h0, p, 3'h0, r}, v);
    wait_idle();
    rd(`PMSP_OFF_DATA, v);
    chk("rd_data", {3'h5, p, 3'h3, r}, v);
    chk("rd_frame", {18'h0, 32'hffffffff, 2'b01, 2'b10, p, r},
        {18'h0, frame[63:18]});
    got = v[15:0];
  endtask : t_read

  task automatic t_write(input logic [4:0] p, input logic [4:0] r,
                         input logic [15:0] d);
    logic [31:0] v;
    wr(`PMSP_OFF_DATA, {16'h0, d});
    wr(`PMSP_OFF_CTL, {12'h0, 4'hb, 3'h0, p, 3'h0, r});
    wr(`PMSP_OFF_DATA, 32'h0000dead);
    wr(`PMSP_OFF_CTL, 32'h0);
    wait_idle();
    chk("wr_frame", {32'hffffffff, 2'b01, 2'b01, p, r, 2'b10, d},
        frame);
    rd(`PMSP_OFF_DATA, v);
    chk("wr_kept", {48'h0, d}, v);
    rd(`PMSP_OFF_CTL, v);
    chk("ctl_kept", {32'h0, 12'h0, 4'h9, 3'h0, p, 3'h0, r}, v);
  endtask : t_write

  task automatic t_mode();
    logic [15:0] ab;
    logic [31:0] v;
    t_read(5'h01, 5'h05, ab);
    wr(`PMSP_OFF_MCMD, {11'h0, ab[0], 1'b0, ab[2], 18'h0});
    chk("mode_out", 64'h3, {spd, fdx});
    rd(`PMSP_OFF_MCMD, v);
    chk("mcmd_rb", 64'h00140000, v);
  endtask : t_mode

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  initial begin
    logic [15:0] g;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_period(8'h02);
    t_period(8'h07);
    t_noen();
    t_read(5'h1f, 5'h12, g);
    t_write(5'h0a, 5'h1f, 16'ha5c3);
    t_mode();
    end_sim();
  end
endmodule : tb_phy_mgmt_serial_port
